//--- src/srsi_map.vh
`ifndef SRSI_MAP_VH
`define SRSI_MAP_VH

// timing
`define SRSI_CLK_NS 10
`define SRSI_MC_NS 40
`define SRSI_MC_CLKS (`SRSI_MC_NS / `SRSI_CLK_NS)
`define SRSI_SOFT_MC 2

// widths
`define SRSI_PC_W 12
`define SRSI_NPORT 14
`define SRSI_NIB_W 4

// reset values
`define SRSI_PC_RST 12'h000
`define SRSI_NIB_RST 4'h0
`define SRSI_BIT_RST 1'b0
`define SRSI_PORT_LATCH_RST 14'h3FFF
`define SRSI_PORT_PP_RST 14'h0000
`define SRSI_PORT_PU_RST 14'h0000
// pins 0 and 1 (first two d-port pins) have no pull-up
`define SRSI_PU_MASK 14'h3FFC

// write selects
`define SRSI_SEL_IRQ_ALLOW 4'h0
`define SRSI_SEL_MASK_ONE 4'h1
`define SRSI_SEL_MASK_TWO 4'h2
`define SRSI_SEL_PRESCALE 4'h3
`define SRSI_SEL_TMR_ONE 4'h4
`define SRSI_SEL_TMR_TWO 4'h5
`define SRSI_SEL_TMR_AUX 4'h6
`define SRSI_SEL_OSC 4'h7
`define SRSI_SEL_SER_PORT 4'h8
`define SRSI_SEL_SI 4'h9
`define SRSI_SEL_LATCH 4'hA
`define SRSI_SEL_PP 4'hB
`define SRSI_SEL_PU 4'hC

`endif

//--- src/srsi_pin_sync.v
`timescale 1ns/1ps
module srsi_pin_sync
(
    clk,
    resetn,
    pin_in,
    pin_sync
);
input wire clk;
input wire resetn;
input wire pin_in;
output wire pin_sync;

reg meta_r;
reg sync_r;

// idles high so a released pin does not look like a reset
always @(posedge clk)
begin
    if (!resetn)
    begin
        meta_r <= 1'b1;
        sync_r <= 1'b1;
    end
    else
    begin
        meta_r <= pin_in;
        sync_r <= meta_r;
    end
end

assign pin_sync = sync_r;

endmodule // srsi_pin_sync

//--- src/srsi_reset_ctrl.v
`timescale 1ns/1ps
`include "srsi_map.vh"

// Operation
// - soft reset instruction drives the reset pin low, causing full system reset
// - all port pins are high-impedance during reset
// - reset sets every port output latch to one
// - reset selects n-channel open-drain output structure for all ports
// - reset turns pull-ups off; first two d-port pins have none
// - reset loads program counter with address zero of page zero
// - reset clears global interrupt allow flag and both interrupt mask registers
// - reset clears prescaler control register, prescaler stopped
// - reset clears timer one control, timer one stopped
// - reset clears the 4-bit timer two control to zero
// - reset clears the 4-bit auxiliary timer control to zero
// - reset clears oscillator select, on-chip oscillator runs
// - reset clears the serial done flag
// - reset clears serial port control, no pin given to serial
// - 8-bit serial shift register is never initialised by reset
// - reset values still hold after release; other state is software's job
// - on reset pin release execution starts at address zero page zero
module srsi_reset_ctrl
#(
    parameter PC_W = `SRSI_PC_W,
    parameter NPORT = `SRSI_NPORT,
    parameter MC_CLKS = `SRSI_MC_CLKS,
    parameter SOFT_MC = `SRSI_SOFT_MC
)
(
    clk,
    resetn,
    reset_pin_in,
    reset_pin_out,
    reset_pin_oe,
    soft_reset_instruction,
    cpu_wr,
    cpu_wr_sel,
    cpu_wr_data,
    cpu_pc_load,
    cpu_pc_val,
    cpu_pc_step,
    serial_shift,
    serial_in,
    serial_done_evt,
    serial_start,
    cpu_run,
    machine_cycle,
    program_counter,
    global_irq_allow_flag,
    irq_mask_reg_one,
    irq_mask_reg_two,
    prescaler_control_reg,
    timer_one_control,
    timer_two_control,
    timer_aux_control,
    osc_select_reg,
    serial_done_flag,
    serial_port_control,
    serial_shift_reg,
    port_latch,
    port_push_pull,
    port_pullup,
    port_oe
);
input wire clk;
input wire resetn;
input wire reset_pin_in;
output reg reset_pin_out;
output reg reset_pin_oe;
input wire soft_reset_instruction;
input wire cpu_wr;
input wire [3:0] cpu_wr_sel;
input wire [NPORT-1:0] cpu_wr_data;
input wire cpu_pc_load;
input wire [PC_W-1:0] cpu_pc_val;
input wire cpu_pc_step;
input wire serial_shift;
input wire serial_in;
input wire serial_done_evt;
input wire serial_start;
output reg cpu_run;
output reg machine_cycle;
output reg [PC_W-1:0] program_counter;
output reg global_irq_allow_flag;
output reg [3:0] irq_mask_reg_one;
output reg [3:0] irq_mask_reg_two;
output reg prescaler_control_reg;
output reg [3:0] timer_one_control;
output reg [3:0] timer_two_control;
output reg [3:0] timer_aux_control;
output reg osc_select_reg;
output reg serial_done_flag;
output reg [3:0] serial_port_control;
output reg [7:0] serial_shift_reg;
output reg [NPORT-1:0] port_latch;
output reg [NPORT-1:0] port_push_pull;
output reg [NPORT-1:0] port_pullup;
output reg [NPORT-1:0] port_oe;

localparam integer MC_LAST_I = MC_CLKS - 1;
localparam integer SOFT_LAST_I = SOFT_MC - 1;
localparam [7:0] MC_LAST = MC_LAST_I[7:0];
localparam [7:0] SOFT_LAST = SOFT_LAST_I[7:0];
localparam [NPORT-1:0] PU_MASK = `SRSI_PU_MASK;

wire pin_sync;
reg [7:0] mc_cnt_r;
reg [7:0] soft_cnt_r;
reg sys_rst_r;
reg sys_rst_nxt;
wire wr_ok;
wire rst_all;

srsi_pin_sync u_pin_sync
(
    .clk(clk),
    .resetn(resetn),
    .pin_in(reset_pin_in),
    .pin_sync(pin_sync)
);

function sel_hit;
    input [3:0] sel;
    begin
        sel_hit = wr_ok && (cpu_wr_sel == sel);
    end
endfunction

// writes are dropped while reset holds
assign wr_ok = cpu_wr && !sys_rst_r;

// covers the first reset cycle too, so no state lags cpu_run going low
assign rst_all = !resetn || sys_rst_nxt || sys_rst_r;

// machine cycle divider, runs through reset so the pin is sampled
always @(posedge clk)
begin
    if (!resetn)
    begin
        mc_cnt_r <= 8'h00;
        machine_cycle <= 1'b0;
    end
    else if (mc_cnt_r == MC_LAST)
    begin
        mc_cnt_r <= 8'h00;
        machine_cycle <= 1'b1;
    end
    else
    begin
        mc_cnt_r <= mc_cnt_r + 8'h01;
        machine_cycle <= 1'b0;
    end
end

// open-drain pull of the reset pin on soft reset
always @(posedge clk)
begin
    reset_pin_out <= 1'b0;
    if (!resetn)
    begin
        reset_pin_oe <= 1'b0;
        soft_cnt_r <= 8'h00;
    end
    else if (!reset_pin_oe)
    begin
        soft_cnt_r <= 8'h00;
        if (soft_reset_instruction && cpu_run)
            reset_pin_oe <= 1'b1;
    end
    else if (machine_cycle)
    begin
        // held whole machine cycles so our own pin read qualifies
        if (soft_cnt_r == SOFT_LAST)
            reset_pin_oe <= 1'b0;
        else
            soft_cnt_r <= soft_cnt_r + 8'h01;
    end
end

// internal reset: pin low seen on a machine cycle edge, or our own drive
always @*
begin
    sys_rst_nxt = sys_rst_r;
    if (machine_cycle && !pin_sync)
        sys_rst_nxt = 1'b1;
    else if (reset_pin_oe)
        sys_rst_nxt = 1'b1;
    else if (pin_sync)
        sys_rst_nxt = 1'b0;
end

always @(posedge clk)
begin
    if (!resetn)
    begin
        sys_rst_r <= 1'b1;
        cpu_run <= 1'b0;
    end
    else
    begin
        sys_rst_r <= sys_rst_nxt;
        cpu_run <= !sys_rst_nxt;
    end
end

// program counter
always @(posedge clk)
begin
    if (rst_all)
        program_counter <= `SRSI_PC_RST;
    else if (cpu_pc_load)
        program_counter <= cpu_pc_val;
    else if (cpu_pc_step)
        program_counter <= program_counter + {{(PC_W-1){1'b0}}, 1'b1};
end

// control registers; cleared for every reset source
always @(posedge clk)
begin
    if (rst_all)
    begin
        global_irq_allow_flag <= `SRSI_BIT_RST;
        irq_mask_reg_one <= `SRSI_NIB_RST;
        irq_mask_reg_two <= `SRSI_NIB_RST;
        prescaler_control_reg <= `SRSI_BIT_RST;
        timer_one_control <= `SRSI_NIB_RST;
        timer_two_control <= `SRSI_NIB_RST;
        timer_aux_control <= `SRSI_NIB_RST;
        osc_select_reg <= `SRSI_BIT_RST;
        serial_port_control <= `SRSI_NIB_RST;
    end
    else
    begin
        if (sel_hit(`SRSI_SEL_IRQ_ALLOW))
            global_irq_allow_flag <= cpu_wr_data[0];
        if (sel_hit(`SRSI_SEL_MASK_ONE))
            irq_mask_reg_one <= cpu_wr_data[3:0];
        if (sel_hit(`SRSI_SEL_MASK_TWO))
            irq_mask_reg_two <= cpu_wr_data[3:0];
        if (sel_hit(`SRSI_SEL_PRESCALE))
            prescaler_control_reg <= cpu_wr_data[0];
        if (sel_hit(`SRSI_SEL_TMR_ONE))
            timer_one_control <= cpu_wr_data[3:0];
        if (sel_hit(`SRSI_SEL_TMR_TWO))
            timer_two_control <= cpu_wr_data[3:0];
        if (sel_hit(`SRSI_SEL_TMR_AUX))
            timer_aux_control <= cpu_wr_data[3:0];
        if (sel_hit(`SRSI_SEL_OSC))
            osc_select_reg <= cpu_wr_data[0];
        if (sel_hit(`SRSI_SEL_SER_PORT))
            serial_port_control <= cpu_wr_data[3:0];
    end
end

// serial done flag: a completion in the start cycle is kept
always @(posedge clk)
begin
    if (rst_all)
        serial_done_flag <= `SRSI_BIT_RST;
    else if (serial_done_evt)
        serial_done_flag <= 1'b1;
    else if (serial_start)
        serial_done_flag <= 1'b0;
end

// shift register has no reset branch at all; contents undefined
always @(posedge clk)
begin
    if (sel_hit(`SRSI_SEL_SI))
        serial_shift_reg <= cpu_wr_data[7:0];
    else if (serial_shift && !sys_rst_r)
        serial_shift_reg <= {serial_shift_reg[6:0], serial_in};
end

// port configuration
always @(posedge clk)
begin
    if (rst_all)
    begin
        port_latch <= `SRSI_PORT_LATCH_RST;
        port_push_pull <= `SRSI_PORT_PP_RST;
        port_pullup <= `SRSI_PORT_PU_RST;
    end
    else
    begin
        if (sel_hit(`SRSI_SEL_LATCH))
            port_latch <= cpu_wr_data;
        if (sel_hit(`SRSI_SEL_PP))
            port_push_pull <= cpu_wr_data;
        if (sel_hit(`SRSI_SEL_PU))
            port_pullup <= cpu_wr_data & PU_MASK;
    end
end

// pin drivers; open-drain only drives a low latch
always @(posedge clk)
begin
    if (rst_all)
        port_oe <= {NPORT{1'b0}};
    else
        port_oe <= port_push_pull | ~port_latch;
end

endmodule // srsi_reset_ctrl

//--- dv/srsi_pin_src.sv
`timescale 1ns/1ps
module srsi_pin_src
#(
    parameter HOLD = 10
)
(
    input wire clk,
    input wire go,
    output wire ext_low
);
    integer cnt_r = 0;
    // longer than a machine cycle plus sync, since the pin is only sampled on pulses
    always @(posedge clk)
    begin
        if (go)
            cnt_r <= HOLD;
        else if (cnt_r > 0)
            cnt_r <= cnt_r - 1;
    end
    assign ext_low = (cnt_r != 0);
endmodule // srsi_pin_src

//--- dv/srsi_reset_ctrl_chk.sv
`timescale 1ns/1ps
module srsi_chk
#(
    parameter PC_W = 12,
    parameter NPORT = 14
)
(
    input wire clk, resetn, reset_pin_oe, reset_pin_out, soft_reset_instruction, cpu_wr, cpu_run,
    input wire [3:0] cpu_wr_sel,
    input wire [NPORT-1:0] cpu_wr_data, port_latch, port_push_pull, port_pullup, port_oe,
    input wire [PC_W-1:0] program_counter,
    input wire global_irq_allow_flag, prescaler_control_reg, osc_select_reg, serial_done_flag,
    input wire [3:0] irq_mask_reg_one, irq_mask_reg_two, timer_one_control, timer_two_control,
    input wire [3:0] timer_aux_control, serial_port_control
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire [27:0] ctl = {global_irq_allow_flag, irq_mask_reg_one, irq_mask_reg_two, prescaler_control_reg,
        timer_one_control, timer_two_control, timer_aux_control, osc_select_reg, serial_done_flag,
        serial_port_control};
    a_soft_pin_low: assert property (soft_reset_instruction && cpu_run && !reset_pin_oe |=>
        reset_pin_oe && !reset_pin_out) else $error("soft reset did not pull pin");
    a_soft_halts: assert property ($rose(reset_pin_oe) |-> ##[1:2] !cpu_run)
        else $error("pin pull did not reset");
    a_pull_bounded: assert property ($rose(reset_pin_oe) |-> ##[4:8] !reset_pin_oe)
        else $error("pin pull length wrong");
    a_ports_hiz: assert property (!cpu_run |-> port_oe == 14'h0000) else $error("port driven in reset");
    a_latch_ones: assert property (!cpu_run |-> &port_latch) else $error("latch not set");
    a_open_drain: assert property (!cpu_run |-> !(|port_push_pull)) else $error("push-pull in reset");
    a_pullup_off: assert property (port_pullup[1:0] == 2'h0 && (cpu_run || !(|port_pullup)))
        else $error("pull-up on");
    a_start_zero: assert property ($rose(cpu_run) |-> program_counter == 12'h000 && ctl == 28'h0)
        else $error("bad start state");
    a_irq_off: assert property (!cpu_run |-> ctl[27:19] == 9'h000) else $error("irq enabled in reset");
    a_timers_off: assert property (!cpu_run |-> ctl[18:6] == 13'h0000) else $error("timer ctl set");
    a_osc_serial: assert property (!cpu_run |-> ctl[5:0] == 6'h00) else $error("osc or serial set");
    a_write_lands: assert property (cpu_run && cpu_wr && cpu_wr_sel == 4'h5 ##1 cpu_run |->
        timer_two_control == $past(cpu_wr_data[3:0])) else $error("write lost");
    c_soft: cover property ($rose(reset_pin_oe));
    c_release: cover property ($rose(cpu_run));
    c_write: cover property (cpu_run && cpu_wr);
endmodule // srsi_chk
bind srsi_reset_ctrl srsi_chk #(.PC_W(PC_W), .NPORT(NPORT)) u_chk (.*);

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "srsi_map.vh"
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, soft_reset_instruction = 1'b0, cpu_wr = 1'b0, go = 1'b0;
    logic cpu_pc_load = 1'b0, cpu_pc_step = 1'b0, serial_shift = 1'b0, serial_in = 1'b0;
    logic serial_done_evt = 1'b0, serial_start = 1'b0;
    logic [3:0] cpu_wr_sel = 4'h0;
    logic [13:0] cpu_wr_data = 14'h0000;
    logic [11:0] cpu_pc_val = 12'h000;
    wire reset_pin_out, reset_pin_oe, cpu_run, machine_cycle, ext_low;
    wire global_irq_allow_flag, prescaler_control_reg, osc_select_reg, serial_done_flag;
    wire [3:0] irq_mask_reg_one, irq_mask_reg_two, timer_one_control, timer_two_control;
    wire [3:0] timer_aux_control, serial_port_control;
    wire [11:0] program_counter;
    wire [7:0] serial_shift_reg;
    wire [13:0] port_latch, port_push_pull, port_pullup, port_oe;
    // pin has a pull-up; either party may pull it low
    wire rst_pin = reset_pin_oe ? reset_pin_out : !ext_low;
    wire [27:0] ctl = {global_irq_allow_flag, irq_mask_reg_one, irq_mask_reg_two, prescaler_control_reg,
        timer_one_control, timer_two_control, timer_aux_control, osc_select_reg, serial_done_flag,
        serial_port_control};
    integer num_errors = 0, cmp_count = 0, cyc = 0, i;
    srsi_reset_ctrl dut (.reset_pin_in(rst_pin), .*);
    srsi_pin_src u_src (.clk(clk), .go(go), .ext_low(ext_low));
    initial forever #5 clk = !clk;
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    task cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task rstv;
        cmp({program_counter, ctl}, {24'h0, 40'h0}, "ctrl");
        cmp({port_latch, port_push_pull, port_pullup, port_oe}, {14'h3FFF, 42'h0}, "ports");
    endtask
    task wait_run(input logic v);
        integer n;
        n = 0;
        while (cpu_run !== v && n < 100)
        begin
            @(negedge clk);
            n = n + 1;
        end
        cmp(cpu_run, v, "run");
    endtask
    task wr(input logic [3:0] s, input logic [13:0] d);
        @(negedge clk);
        cpu_wr = 1'b1;
        cpu_wr_sel = s;
        cpu_wr_data = d;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rstv;
        resetn = 1'b1;
        wait_run(1'b1);
        rstv;
        $display("test reset_values done");
        for (i = 0; i < 14; i++)
            wr(i[3:0], 14'h3FFF);
        wr(4'hA, 14'h1234);
        wr(4'hB, 14'h00FF);
        @(negedge clk);
        {cpu_pc_val, cpu_pc_load, serial_done_evt, serial_shift} = {12'hABC, 3'h7};
        @(negedge clk);
        {cpu_pc_load, serial_done_evt, serial_shift, cpu_pc_step} = 4'h1;
        @(negedge clk);
        cpu_pc_step = 1'b0;
        @(negedge clk);
        cmp({program_counter, ctl}, {24'h0, 12'hABD, 28'hFFFFFFF}, "writes");
        cmp({port_latch, port_push_pull, port_pullup, port_oe, serial_shift_reg},
            {14'h1234, 14'h00FF, 14'h3FFC, 14'h2DFF, 8'hFE}, "port writes");
        $display("test writes done");
        while (machine_cycle !== 1'b1)
            @(negedge clk);
        i = 1;
        @(negedge clk);
        while (machine_cycle !== 1'b1 && i < 10)
        begin
            @(negedge clk);
            i = i + 1;
        end
        cmp(i, `SRSI_MC_CLKS, "machine cycle");
        @(negedge clk);
        soft_reset_instruction = 1'b1;
        @(negedge clk);
        soft_reset_instruction = 1'b0;
        wait_run(1'b0);
        cmp(rst_pin, 1'b0, "pin low");
        rstv;
        wr(4'h9, 14'h0003);
        wait_run(1'b1);
        rstv;
        cmp(serial_shift_reg, 8'hFE, "shift reg kept");
        $display("test soft_reset done");
        wr(4'h0, 14'h0001);
        cmp(global_irq_allow_flag, 1'b1, "irq allow set");
        @(negedge clk);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        wait_run(1'b0);
        rstv;
        wait_run(1'b1);
        rstv;
        $display("test pin_reset done");
        test_done;
    end
endmodule // tb_top
